// ---- logic/bsrb_consts.vh ----
// Offsets, field positions, codes and reset values of the boiler status register bank
`ifndef BSRB_CONSTS_VH
`define BSRB_CONSTS_VH
`define BSRB_ADDR_FIRST 16'h000F
`define BSRB_ADDR_LAST 16'h0021
`define BSRB_OFS_CURRENT_TERMINAL 16'h000F
`define BSRB_OFS_HEAT_SETPOINT 16'h0010
`define BSRB_OFS_HOT_WATER_SETPOINT 16'h0011
`define BSRB_OFS_LEAD_LAG_SETPOINT 16'h0012
`define BSRB_OFS_WRITE_PERMISSION 16'h0013
`define BSRB_OFS_STEAM_PRESSURE 16'h0014
`define BSRB_OFS_MODULATION_INPUT 16'h0015
`define BSRB_OFS_PRESSURE_SETPOINT 16'h0016
`define BSRB_OFS_CHANGE_FLAGS 16'h0017
`define BSRB_OFS_RESERVED 16'h0018
`define BSRB_OFS_HEAT_OPERATING 16'h0019
`define BSRB_OFS_HOT_WATER_OPERATING 16'h001A
`define BSRB_OFS_LEAD_LAG_OPERATING 16'h001B
`define BSRB_OFS_SYSTEM_OPERATING 16'h001C
`define BSRB_OFS_SYSTEM_SETPOINT 16'h001D
`define BSRB_OFS_ON_HYSTERESIS 16'h001E
`define BSRB_OFS_OFF_HYSTERESIS 16'h001F
`define BSRB_OFS_BURNER_STATUS 16'h0020
`define BSRB_OFS_BURNER_SEQUENCE 16'h0021
`define BSRB_BIT_PLATE_STATUS 3
`define BSRB_BIT_PLATE_CONFIG 4
`define BSRB_FLAGS_MASK 16'h0018
`define BSRB_PERM_NONE 16'h0000
`define BSRB_PERM_INSTALLER 16'h0001
`define BSRB_PERM_MANUFACTURER_LEVEL 16'h0002
`define BSRB_PERM_ALL 16'h0003
`define BSRB_BURNER_DISABLED 16'h0000
`define BSRB_BURNER_LOCKED_OUT 16'h0001
`define BSRB_BURNER_ANTI_SHORT_CYCLE 16'h0004
`define BSRB_BURNER_UNCONFIGURED 16'h0005
`define BSRB_BURNER_STANDBY_HOLD 16'h0022
`define BSRB_BURNER_STANDBY_DELAY 16'h0023
`define BSRB_BURNER_NORMAL_STANDBY 16'h0030
`define BSRB_BURNER_PREPARING 16'h0031
`define BSRB_BURNER_IGNITION 16'h0032
`define BSRB_BURNER_FIRING 16'h0033
`define BSRB_BURNER_POSTPURGE 16'h0034
`define BSRB_TEMP_MIN 16'hFE70
`define BSRB_TEMP_MAX 16'h0514
`define BSRB_HYST_MAX 16'h0514
`define BSRB_PRESSURE_MAX 16'h05DC
`define BSRB_EXC_ILLEGAL_ADDRESS 8'h02
`define BSRB_ZERO16 16'h0000
`endif

// ---- logic/bsrb_read_mux.v ----
// Registered read data selector for the status register bank
`timescale 1ns/1ps
`default_nettype none
`include "bsrb_consts.vh"
module bsrb_read_mux
(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Select
   input wire i_load,
   input wire [15:0] i_addr,
   // Values
   input wire [15:0] i_current_terminal,
   input wire [15:0] i_heat_setpoint,
   input wire [15:0] i_hot_water_setpoint,
   input wire [15:0] i_lead_lag_setpoint,
   input wire [15:0] i_write_permission,
   input wire [15:0] i_steam_pressure,
   input wire [15:0] i_modulation_input,
   input wire [15:0] i_pressure_setpoint,
   input wire [15:0] i_change_flags,
   input wire [15:0] i_heat_operating,
   input wire [15:0] i_hot_water_operating,
   input wire [15:0] i_lead_lag_operating,
   input wire [15:0] i_system_operating,
   input wire [15:0] i_system_setpoint,
   input wire [15:0] i_on_hysteresis,
   input wire [15:0] i_off_hysteresis,
   input wire [15:0] i_burner_status,
   input wire [15:0] i_burner_sequence,
   // Result
   output reg [15:0] o_data
);
   reg [15:0] next_data;
   always @*
   begin
      case (i_addr)
         `BSRB_OFS_CURRENT_TERMINAL: next_data = i_current_terminal;
         `BSRB_OFS_HEAT_SETPOINT: next_data = i_heat_setpoint;
         `BSRB_OFS_HOT_WATER_SETPOINT: next_data = i_hot_water_setpoint;
         `BSRB_OFS_LEAD_LAG_SETPOINT: next_data = i_lead_lag_setpoint;
         `BSRB_OFS_WRITE_PERMISSION: next_data = i_write_permission;
         `BSRB_OFS_STEAM_PRESSURE: next_data = i_steam_pressure;
         `BSRB_OFS_MODULATION_INPUT: next_data = i_modulation_input;
         `BSRB_OFS_PRESSURE_SETPOINT: next_data = i_pressure_setpoint;
         `BSRB_OFS_CHANGE_FLAGS: next_data = i_change_flags;
         `BSRB_OFS_HEAT_OPERATING: next_data = i_heat_operating;
         `BSRB_OFS_HOT_WATER_OPERATING: next_data = i_hot_water_operating;
         `BSRB_OFS_LEAD_LAG_OPERATING: next_data = i_lead_lag_operating;
         `BSRB_OFS_SYSTEM_OPERATING: next_data = i_system_operating;
         `BSRB_OFS_SYSTEM_SETPOINT: next_data = i_system_setpoint;
         `BSRB_OFS_ON_HYSTERESIS: next_data = i_on_hysteresis;
         `BSRB_OFS_OFF_HYSTERESIS: next_data = i_off_hysteresis;
         `BSRB_OFS_BURNER_STATUS: next_data = i_burner_status;
         `BSRB_OFS_BURNER_SEQUENCE: next_data = i_burner_sequence;
         default: next_data = `BSRB_ZERO16;
      endcase
   end
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_data <= `BSRB_ZERO16;
      else if (i_load)
         o_data <= next_data;
   end
endmodule // bsrb_read_mux
`default_nettype wire

// ---- logic/bsrb_status_bank.v ----
// Boiler status holding register bank, read by the protocol engine one word at a time
// Summary of operation
// - The write permission register reads 0 none, 1 installer, 2 manufacturer level, 3 all.
// - Reading the change-flag register returns its bits and then clears all of them.
// - Change-flag bit 4 marks plate exchanger configuration change, bit 3 its status change, others zero.
// - The burner status register carries only the defined codes 0,1,4,5,34,35,48..52.
// - The modulation input reads the current terminal value in 0.1 mA only with signal present in current mode, else 0.
// - The active heating setpoint is the one picked by the heating setpoint source, 0.1 C, -40..130.
// - The active hot water setpoint is the one picked by its source, 0.1 C, -40..130.
// - The active lead-lag setpoint is the one picked by its source, 0.1 C, -40..130.
// - Steam pressure and the pressure setpoint are unsigned 0.1 psi counts from 0 to 150 psi.
// - The on and off hysteresis registers hold 0..130 C in 0.1 C steps.
// - The current terminal register reports 0.1 mA in current mode, else a mode-defined value.
// - The burner sequence state register reports the sequencer code as given, model decoded elsewhere.
// - The four operating point registers report 0.1 C values over -40..130.
`timescale 1ns/1ps
`default_nettype none
`include "bsrb_consts.vh"
module bsrb_status_bank
(
   // Clock and reset
   input wire i_clk_sys,
   input wire i_rst,
   // Access request from the protocol engine
   input wire i_req,
   input wire i_req_write,
   input wire [15:0] i_req_addr,
   // Answer to the protocol engine
   output reg o_ack,
   output reg o_exception,
   output reg [7:0] o_exception_code,
   output wire [15:0] o_rdata,
   // Change events
   input wire i_plate_config_changed,
   input wire i_plate_status_changed,
   // Access level
   input wire [1:0] i_write_level,
   // Analog terminal
   input wire i_terminal_current_mode,
   input wire [15:0] i_terminal_raw,
   input wire i_modulation_signal_present,
   // Setpoint sources
   input wire [15:0] i_heat_setpoint,
   input wire [15:0] i_hot_water_setpoint,
   input wire [15:0] i_lead_lag_setpoint,
   input wire [15:0] i_pressure_setpoint,
   input wire [15:0] i_steam_pressure,
   // Operating points
   input wire [15:0] i_heat_operating,
   input wire [15:0] i_hot_water_operating,
   input wire [15:0] i_lead_lag_operating,
   input wire [15:0] i_system_operating,
   input wire [15:0] i_system_setpoint,
   input wire [15:0] i_on_hysteresis,
   input wire [15:0] i_off_hysteresis,
   // Burner control
   input wire [15:0] i_burner_status,
   input wire [15:0] i_burner_sequence
);
   reg [15:0] change_flags;
   reg [15:0] write_permission;
   reg [15:0] current_terminal;
   reg [15:0] modulation_input;
   reg [15:0] heat_setpoint;
   reg [15:0] hot_water_setpoint;
   reg [15:0] lead_lag_setpoint;
   reg [15:0] pressure_setpoint;
   reg [15:0] steam_pressure;
   reg [15:0] heat_operating;
   reg [15:0] hot_water_operating;
   reg [15:0] lead_lag_operating;
   reg [15:0] system_operating;
   reg [15:0] system_setpoint;
   reg [15:0] on_hysteresis;
   reg [15:0] off_hysteresis;
   reg [15:0] burner_status;
   reg [15:0] burner_sequence;
   wire in_range;
   wire read_ok;
   wire flags_read;
   reg [15:0] next_flags;
   reg [15:0] flag_events;

   // Signed temperature clamp to -40.0 .. 130.0 C
   function [15:0] clamp_temp;
      input [15:0] v;
      begin
         if ($signed(v) < $signed(`BSRB_TEMP_MIN))
            clamp_temp = `BSRB_TEMP_MIN;
         else if ($signed(v) > $signed(`BSRB_TEMP_MAX))
            clamp_temp = `BSRB_TEMP_MAX;
         else
            clamp_temp = v;
      end
   endfunction

   // Clamp to 0 .. lim with negative inputs reading zero, used for pressure and hysteresis
   function [15:0] clamp_max;
      input [15:0] v;
      input [15:0] lim;
      begin
         if ($signed(v) < $signed(`BSRB_ZERO16))
            clamp_max = `BSRB_ZERO16;
         else if (v > lim)
            clamp_max = lim;
         else
            clamp_max = v;
      end
   endfunction

   // Undefined burner codes fall back to disabled rather than leak reserved values
   function [15:0] burner_code;
      input [15:0] v;
      begin
         case (v)
            `BSRB_BURNER_DISABLED, `BSRB_BURNER_LOCKED_OUT, `BSRB_BURNER_ANTI_SHORT_CYCLE,
            `BSRB_BURNER_UNCONFIGURED, `BSRB_BURNER_STANDBY_HOLD, `BSRB_BURNER_STANDBY_DELAY,
            `BSRB_BURNER_NORMAL_STANDBY, `BSRB_BURNER_PREPARING, `BSRB_BURNER_IGNITION,
            `BSRB_BURNER_FIRING, `BSRB_BURNER_POSTPURGE:
               burner_code = v;
            default:
               burner_code = `BSRB_BURNER_DISABLED;
         endcase
      end
   endfunction

   assign in_range = (i_req_addr >= `BSRB_ADDR_FIRST) && (i_req_addr <= `BSRB_ADDR_LAST);
   assign read_ok = i_req && !i_req_write && in_range && (i_req_addr != `BSRB_OFS_RESERVED);
   assign flags_read = read_ok && (i_req_addr == `BSRB_OFS_CHANGE_FLAGS);

   always @*
   begin
      flag_events = `BSRB_ZERO16;
      flag_events[`BSRB_BIT_PLATE_CONFIG] = i_plate_config_changed;
      flag_events[`BSRB_BIT_PLATE_STATUS] = i_plate_status_changed;
      // A new event in the read cycle survives the clear and is reported next time
      if (flags_read)
         next_flags = flag_events & `BSRB_FLAGS_MASK;
      else
         next_flags = (change_flags | flag_events) & `BSRB_FLAGS_MASK;
   end

   // Change flags gather events until a read of the flag word empties them
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
         change_flags <= `BSRB_ZERO16;
      else
         change_flags <= next_flags;
   end

   // The two-bit level is widened so the unused upper bits always read zero
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
         write_permission <= `BSRB_PERM_NONE;
      else
         write_permission <= {14'h0000, i_write_level};
   end

   // The modulation word copies the terminal only in current mode,
   // since in other modes the terminal value is no current at all
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         current_terminal <= `BSRB_ZERO16;
         modulation_input <= `BSRB_ZERO16;
      end
      else
      begin
         current_terminal <= i_terminal_raw;
         if (!i_modulation_signal_present)
            modulation_input <= `BSRB_ZERO16;
         else if (i_terminal_current_mode)
            modulation_input <= i_terminal_raw;
         else
            modulation_input <= `BSRB_ZERO16;
      end
   end

   // Setpoints are clamped so a bad source never reports outside the scale
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         heat_setpoint <= `BSRB_ZERO16;
         hot_water_setpoint <= `BSRB_ZERO16;
         lead_lag_setpoint <= `BSRB_ZERO16;
         system_setpoint <= `BSRB_ZERO16;
      end
      else
      begin
         heat_setpoint <= clamp_temp(i_heat_setpoint);
         hot_water_setpoint <= clamp_temp(i_hot_water_setpoint);
         lead_lag_setpoint <= clamp_temp(i_lead_lag_setpoint);
         system_setpoint <= clamp_temp(i_system_setpoint);
      end
   end

   // A negative raw pressure is a sensor fault and reads as zero,
   // so the master never sees a wrapped huge unsigned value
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         steam_pressure <= `BSRB_ZERO16;
         pressure_setpoint <= `BSRB_ZERO16;
      end
      else
      begin
         steam_pressure <= clamp_max(i_steam_pressure, `BSRB_PRESSURE_MAX);
         pressure_setpoint <= clamp_max(i_pressure_setpoint, `BSRB_PRESSURE_MAX);
      end
   end

   // Operating points share the signed temperature scale of the setpoints
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         heat_operating <= `BSRB_ZERO16;
         hot_water_operating <= `BSRB_ZERO16;
         lead_lag_operating <= `BSRB_ZERO16;
         system_operating <= `BSRB_ZERO16;
      end
      else
      begin
         heat_operating <= clamp_temp(i_heat_operating);
         hot_water_operating <= clamp_temp(i_hot_water_operating);
         lead_lag_operating <= clamp_temp(i_lead_lag_operating);
         system_operating <= clamp_temp(i_system_operating);
      end
   end

   // Hysteresis is a width, never negative
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         on_hysteresis <= `BSRB_ZERO16;
         off_hysteresis <= `BSRB_ZERO16;
      end
      else
      begin
         on_hysteresis <= clamp_max(i_on_hysteresis, `BSRB_HYST_MAX);
         off_hysteresis <= clamp_max(i_off_hysteresis, `BSRB_HYST_MAX);
      end
   end

   // The sequence code passes untouched; its meaning depends on the model type
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         burner_status <= `BSRB_BURNER_DISABLED;
         burner_sequence <= `BSRB_ZERO16;
      end
      else
      begin
         burner_status <= burner_code(i_burner_status);
         burner_sequence <= i_burner_sequence;
      end
   end

   // Answer one cycle after each request; writes never reach any register
   always @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_ack <= 1'b0;
         o_exception <= 1'b0;
         o_exception_code <= 8'h00;
      end
      else
      begin
         o_ack <= i_req;
         o_exception <= i_req && !read_ok;
         o_exception_code <= (i_req && !read_ok) ? `BSRB_EXC_ILLEGAL_ADDRESS : 8'h00;
      end
   end

   bsrb_read_mux u_read_mux
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_load(read_ok),
      .i_addr(i_req_addr),
      .i_current_terminal(current_terminal),
      .i_heat_setpoint(heat_setpoint),
      .i_hot_water_setpoint(hot_water_setpoint),
      .i_lead_lag_setpoint(lead_lag_setpoint),
      .i_write_permission(write_permission),
      .i_steam_pressure(steam_pressure),
      .i_modulation_input(modulation_input),
      .i_pressure_setpoint(pressure_setpoint),
      .i_change_flags(change_flags),
      .i_heat_operating(heat_operating),
      .i_hot_water_operating(hot_water_operating),
      .i_lead_lag_operating(lead_lag_operating),
      .i_system_operating(system_operating),
      .i_system_setpoint(system_setpoint),
      .i_on_hysteresis(on_hysteresis),
      .i_off_hysteresis(off_hysteresis),
      .i_burner_status(burner_status),
      .i_burner_sequence(burner_sequence),
      .o_data(o_rdata)
   );
endmodule // bsrb_status_bank
`default_nettype wire

// ---- verif/bsrb_master_model.sv ----
// Master-side model issuing single-word accesses to the bank
`timescale 1ns/1ps
`default_nettype none
module bsrb_master_model
(
   // Clock
   input wire logic i_clk_sys,
   // Request
   output logic o_req = 1'b0,
   output logic o_req_write = 1'b0,
   output logic [15:0] o_req_addr = 16'h0000,
   // Answer
   input wire logic i_ack,
   input wire logic i_exception,
   input wire logic [7:0] i_exception_code,
   input wire logic [15:0] i_rdata
);
   // Released fields are scrambled so a stale address can never pass for a held one
   task automatic access(input logic w, input logic [15:0] a, output logic k, output logic e,
      output logic [7:0] c, output logic [15:0] d);
      @(negedge i_clk_sys);
      o_req = 1'b1;
      o_req_write = w;
      o_req_addr = a;
      @(negedge i_clk_sys);
      o_req = 1'b0;
      o_req_write = ~w;
      o_req_addr = ~a;
      k = i_ack;
      e = i_exception;
      c = i_exception_code;
      d = i_rdata;
   endtask
endmodule // bsrb_master_model
`default_nettype wire

// ---- verif/bsrb_status_bank_asserts.sv ----
// Concurrent checks on the status bank request and answer ports
`timescale 1ns/1ps
`default_nettype none
module bsrb_status_bank_asserts
(
   // Clock, reset and request
   input wire logic i_clk_sys, input wire logic i_rst, input wire logic i_req,
   input wire logic i_req_write, input wire logic [15:0] i_req_addr,
   // Answer and change events
   input wire logic o_ack, input wire logic o_exception, input wire logic [7:0] o_exception_code,
   input wire logic [15:0] o_rdata, input wire logic i_plate_config_changed,
   input wire logic i_plate_status_changed
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic evt;
   logic addr_ok;
   assign evt = i_plate_config_changed || i_plate_status_changed;
   assign addr_ok = i_req_addr >= 16'h000F && i_req_addr <= 16'h0021 && i_req_addr != 16'h0018;
   sequence flag_rd;
      i_req && !i_req_write && i_req_addr == 16'h0017 && !evt;
   endsequence
   ack_after_req_a: assert property (i_req |=> o_ack)
      else $error("answer missing after request");
   ack_has_cause_a: assert property (o_ack |-> $past(i_req))
      else $error("answer without request");
   exc_code_a: assert property (o_ack |-> o_exception_code == (o_exception ? 8'h02 : 8'h00))
      else $error("wrong refusal code");
   exc_needs_ack_a: assert property (o_exception |-> o_ack)
      else $error("refusal outside an answer");
   write_refused_a: assert property (i_req && i_req_write |=> o_exception)
      else $error("write not refused");
   bad_read_refused_a: assert property (i_req && !addr_ok |=> o_exception)
      else $error("unmapped read not refused");
   good_read_a: assert property (i_req && !i_req_write && addr_ok |=> !o_exception)
      else $error("mapped read refused");
   rdata_hold_a: assert property (!$past(i_rst) && !(o_ack && !o_exception) |-> $stable(o_rdata))
      else $error("read data moved without a read");
   perm_width_a: assert property (o_ack && !o_exception
      && $past(i_req_addr) == 16'h0013 |-> o_rdata[15:2] == 14'h0000)
      else $error("permission code out of range");
   flag_bits_a: assert property (o_ack && !o_exception
      && $past(i_req_addr) == 16'h0017 |-> (o_rdata & 16'hFFE7) == 16'h0000)
      else $error("reserved flag set");
   burner_codes_a: assert property (o_ack && !o_exception
      && $past(i_req_addr) == 16'h0020 |-> o_rdata inside {0, 1, 4, 5, 34, 35, [48:52]})
      else $error("reserved burner code");
   flag_clear_a: assert property (flag_rd ##1 (!evt && !i_req) ##1 flag_rd
      |=> o_rdata == 16'h0000) else $error("change flags not cleared by read");
   cover property (i_req && i_req_write);
   cover property (o_ack && !o_exception && $past(i_req_addr) == 16'h0017 && o_rdata != 16'h0000);
   cover property (o_exception && !$past(i_req_write));
endmodule // bsrb_status_bank_asserts
bind bsrb_status_bank bsrb_status_bank_asserts chk
(
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req), .i_req_write(i_req_write),
   .i_req_addr(i_req_addr), .o_ack(o_ack), .o_exception(o_exception),
   .o_exception_code(o_exception_code), .o_rdata(o_rdata),
   .i_plate_config_changed(i_plate_config_changed),
   .i_plate_status_changed(i_plate_status_changed)
);
`default_nettype wire

// ---- verif/bsrb_status_bank_test.sv ----
// Self-checking bench for the boiler status register bank
`timescale 1ns/1ps
`default_nettype none
module bsrb_status_bank_test;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req, req_write, ack, exc, cfg_chg = 1'b0, sts_chg = 1'b0, cur_mode = 1'b1, sig_on = 1'b1;
   logic [15:0] req_addr, rdata, last_exp = 16'h0000;
   logic [7:0] exc_code;
   logic [1:0] level = 2'b00;
   logic [15:0] v [0:14];
   logic [15:0] map [0:14] = '{16'h000F, 16'h0010, 16'h0011, 16'h0012, 16'h0016, 16'h0014,
      16'h0019, 16'h001A, 16'h001B, 16'h001C, 16'h001D, 16'h001E, 16'h001F, 16'h0020, 16'h0021};
   int n_mismatch = 0, samples_checked = 0, cycles = 0, k;
   bsrb_status_bank uut
   (
      .i_clk_sys(clk_sys), .i_rst(rst), .i_req(req), .i_req_write(req_write),
      .i_req_addr(req_addr), .o_ack(ack), .o_exception(exc), .o_exception_code(exc_code),
      .o_rdata(rdata), .i_plate_config_changed(cfg_chg), .i_plate_status_changed(sts_chg),
      .i_write_level(level), .i_terminal_current_mode(cur_mode), .i_terminal_raw(v[0]),
      .i_modulation_signal_present(sig_on), .i_heat_setpoint(v[1]), .i_hot_water_setpoint(v[2]),
      .i_lead_lag_setpoint(v[3]), .i_pressure_setpoint(v[4]), .i_steam_pressure(v[5]),
      .i_heat_operating(v[6]), .i_hot_water_operating(v[7]), .i_lead_lag_operating(v[8]),
      .i_system_operating(v[9]), .i_system_setpoint(v[10]), .i_on_hysteresis(v[11]),
      .i_off_hysteresis(v[12]), .i_burner_status(v[13]), .i_burner_sequence(v[14])
   );
   bsrb_master_model master
   (
      .i_clk_sys(clk_sys), .o_req(req), .o_req_write(req_write), .o_req_addr(req_addr),
      .i_ack(ack), .i_exception(exc), .i_exception_code(exc_code), .i_rdata(rdata)
   );
   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      logic k2, e;
      logic [7:0] c;
      logic [15:0] d;
      master.access(1'b0, a, k2, e, c, d);
      chk("read answer", {15'h0000, k2 && !e}, 16'h0001);
      chk("read data", d, exp);
      last_exp = exp;
   endtask
   task automatic bad(input logic w, input logic [15:0] a);
      logic k2, e;
      logic [7:0] c;
      logic [15:0] d;
      master.access(w, a, k2, e, c, d);
      chk("refusal", {6'h00, k2, e, c}, 16'h0302);
      chk("held data", d, last_exp);
   endtask
   task automatic done(input string n);
      $display("Test %s finished", n);
   endtask
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         n_mismatch++;
         finish_test;
      end
   end
   initial
   begin
      for (k = 0; k < 15; k++) v[k] = 16'h0000;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      for (k = 0; k < 15; k++) v[k] = 16'h0100 + k[15:0];
      v[1] = 16'hFE70;
      v[2] = 16'h0514;
      v[13] = 16'h0033;
      v[14] = 16'hABCD;
      for (k = 0; k < 15; k++) rd(map[k], v[k]);
      done("values");
      v[1] = 16'hFE6F;
      v[4] = 16'h05DD;
      v[5] = 16'h8000;
      v[6] = 16'h0600;
      v[11] = 16'h0515;
      rd(16'h0010, 16'hFE70);
      rd(16'h0016, 16'h05DC);
      rd(16'h0014, 16'h0000);
      rd(16'h0019, 16'h0514);
      rd(16'h001E, 16'h0514);
      done("limits");
      for (k = 0; k < 4; k++)
      begin
         level = k[1:0];
         rd(16'h0013, {14'h0000, k[1:0]});
      end
      for (k = 0; k < 56; k++)
      begin
         v[13] = k[15:0];
         rd(16'h0020, (k inside {0, 1, 4, 5, 34, 35, [48:52]}) ? k[15:0] : 16'h0000);
      end
      v[0] = 16'h00C8;
      for (k = 0; k < 4; k++)
      begin
         {cur_mode, sig_on} = k[1:0];
         rd(16'h0015, (k == 3) ? 16'h00C8 : 16'h0000);
         rd(16'h000F, 16'h00C8);
      end
      done("codes");
      for (k = 1; k < 4; k++)
      begin
         {cfg_chg, sts_chg} = k[1:0];
         @(negedge clk_sys);
         cfg_chg = 1'b0;
         sts_chg = 1'b0;
         bad(1'b1, 16'h0017);
         rd(16'h0017, {11'h000, k[1:0], 3'b000});
         rd(16'h0017, 16'h0000);
      end
      // An event still high at the clearing read must survive for the next read
      cfg_chg = 1'b1;
      rd(16'h0017, 16'h0010);
      cfg_chg = 1'b0;
      rd(16'h0017, 16'h0010);
      rd(16'h0017, 16'h0000);
      done("flags");
      bad(1'b1, 16'h0010);
      bad(1'b0, 16'h0018);
      bad(1'b0, 16'h000E);
      bad(1'b0, 16'h0022);
      rd(16'h0010, 16'hFE70);
      done("refusals");
      finish_test;
   end
endmodule // bsrb_status_bank_test
`default_nettype wire
